// ---- rtl/timer_regs_pkg.sv ----
/*
  Package for the timer reload and channel value register block: offsets,
  field positions, reset values and the carriers shared by the design.
  Assumes a 32-bit word register port with byte addresses.
*/
package timer_regs_pkg;
  localparam int NUM_CH = 3;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_RELOAD = 8'h2c;
  localparam logic [7:0] OFF_CH_ONE = 8'h34;
  localparam logic [7:0] OFF_CH_TWO = 8'h38;
  localparam logic [7:0] OFF_CH_THREE = 8'h3c;
  localparam logic [7:0] OFF_CTRL = 8'h50;
  localparam logic [7:0] OFF_CH_MODE = 8'h54;
  localparam logic [7:0] OFF_COUNT = 8'h58;
  localparam logic [7:0] OFF_STATUS = 8'h5c;
  localparam logic [7:0] OFF_MASK = 8'h60;
  // Control register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_FORCE_UPD_BIT = 1;
  // Channel mode register: per channel x, bit 4x output/input select,
  // bit 4x+1 shadow enable, bit 4x+2 channel enable
  localparam int MODE_STRIDE = 4;
  localparam int MODE_INPUT_BIT = 0;
  localparam int MODE_SHADOW_BIT = 1;
  localparam int MODE_ENABLE_BIT = 2;
  // Status bits: 0 update, 1..3 channel match, 4..6 channel capture
  localparam int ST_UPDATE_BIT = 0;
  localparam int ST_MATCH_BASE = 1;
  localparam int ST_CAPT_BASE = 4;
  localparam int ST_W = 7;
  localparam logic [31:0] RELOAD_RESET = 32'h0000_0000;
  localparam logic [15:0] CH_RESET = 16'h0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic is_input;
    logic shadow_en;
    logic enable;
  } ch_mode_t;
endpackage : timer_regs_pkg

// ---- rtl/timer_reload_and_compare_regs.sv ----
/*
  Reload limit and three capture/compare channel registers of a 16-bit
  timer, with a small counter that the reload limit governs, update event
  generation, compare outputs, capture and interrupt status.
  Assumes capture inputs are synchronous one-cycle level inputs already
  edge-qualified upstream, and a single-cycle register port master.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_reload_and_compare_regs (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [timer_regs_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [timer_regs_pkg::NUM_CH-1:0] capture_in,
  output logic [timer_regs_pkg::NUM_CH-1:0] channel_output,
  output logic update_event,
  output logic irq
);
  localparam int N = timer_regs_pkg::NUM_CH;
  localparam int MS = timer_regs_pkg::MODE_STRIDE;

  timer_regs_pkg::reg_req_t req;
  timer_regs_pkg::ch_mode_t mode [N];
  logic [31:0] reload_limit_value_reg;
  logic [31:0] active_reload_reg;
  logic [15:0] counter_reg;
  logic run_reg;
  logic force_upd_reg;
  logic [31:0] mode_reg;
  logic [15:0] ch_shadow_reg [N];
  logic [15:0] ch_active_reg [N];
  logic [timer_regs_pkg::ST_W-1:0] status_reg;
  logic [timer_regs_pkg::ST_W-1:0] mask_reg;
  logic [timer_regs_pkg::ST_W-1:0] status_events;
  logic [N-1:0] ch_wr;
  logic [N-1:0] match;
  logic [N-1:0] capt;
  logic reload_hit;
  logic upd;
  logic counting;

  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_mode
      assign mode[g].is_input = mode_reg[g*MS + timer_regs_pkg::MODE_INPUT_BIT];
      assign mode[g].shadow_en = mode_reg[g*MS + timer_regs_pkg::MODE_SHADOW_BIT];
      assign mode[g].enable = mode_reg[g*MS + timer_regs_pkg::MODE_ENABLE_BIT];
    end
  endgenerate

  assign ch_wr[0] = req.wr && req.addr == timer_regs_pkg::OFF_CH_ONE;
  assign ch_wr[1] = req.wr && req.addr == timer_regs_pkg::OFF_CH_TWO;
  assign ch_wr[2] = req.wr && req.addr == timer_regs_pkg::OFF_CH_THREE;

  // Counting stops entirely while the active limit is zero
  assign counting = run_reg && (active_reload_reg != 32'h0000_0000);
  assign reload_hit = counting && ({16'h0000, counter_reg} >= active_reload_reg);
  assign upd = reload_hit || force_upd_reg;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reload_limit_value_reg <= timer_regs_pkg::RELOAD_RESET;
    end else if (req.wr && req.addr == timer_regs_pkg::OFF_RELOAD) begin
      reload_limit_value_reg <= req.wdata;
    end
  end

  // Active limit follows the written one at once while halted, so a zero
  // limit can be left without needing an update that could never come.
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      active_reload_reg <= timer_regs_pkg::RELOAD_RESET;
    end else if (upd || !counting) begin
      active_reload_reg <= reload_limit_value_reg;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      counter_reg <= 16'h0000;
    end else if (req.wr && req.addr == timer_regs_pkg::OFF_COUNT) begin
      counter_reg <= req.wdata[15:0];
    end else if (upd) begin
      counter_reg <= 16'h0000;
    end else if (counting) begin
      counter_reg <= counter_reg + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      run_reg <= 1'b0;
      mode_reg <= 32'h0000_0000;
      mask_reg <= '0;
    end else if (req.wr) begin
      if (req.addr == timer_regs_pkg::OFF_CTRL) begin
        run_reg <= req.wdata[timer_regs_pkg::CTRL_RUN_BIT];
      end
      if (req.addr == timer_regs_pkg::OFF_CH_MODE) begin
        mode_reg <= req.wdata;
      end
      if (req.addr == timer_regs_pkg::OFF_MASK) begin
        mask_reg <= req.wdata[timer_regs_pkg::ST_W-1:0];
      end
    end
  end

  // Forced update is a self-clearing pulse, acted on the cycle after the write
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      force_upd_reg <= 1'b0;
    end else begin
      force_upd_reg <= req.wr && req.addr == timer_regs_pkg::OFF_CTRL
                       && req.wdata[timer_regs_pkg::CTRL_FORCE_UPD_BIT];
    end
  end

  generate
    for (g = 0; g < N; g++) begin : g_ch
      assign capt[g] = mode[g].is_input && mode[g].enable && capture_in[g];
      assign match[g] = !mode[g].is_input && counter_reg == ch_active_reg[g];

      // Shadow holds the software value; in input mode writes are dropped
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          ch_shadow_reg[g] <= timer_regs_pkg::CH_RESET;
        end else if (ch_wr[g] && !mode[g].is_input) begin
          ch_shadow_reg[g] <= req.wdata[15:0];
        end
      end

      // Active register doubles as the capture register in input mode
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          ch_active_reg[g] <= timer_regs_pkg::CH_RESET;
        end else if (mode[g].is_input) begin
          if (capt[g]) begin
            ch_active_reg[g] <= counter_reg;
          end
        end else if (ch_wr[g] && !mode[g].shadow_en) begin
          ch_active_reg[g] <= req.wdata[15:0];
        end else if (upd && mode[g].shadow_en) begin
          ch_active_reg[g] <= ch_shadow_reg[g];
        end
      end

      // Output is high while the counter is below the compare value
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          channel_output[g] <= 1'b0;
        end else begin
          channel_output[g] <= mode[g].enable && !mode[g].is_input
                               && (counter_reg < ch_active_reg[g]);
        end
      end
    end
  endgenerate

  assign status_events = {capt, match, upd};

  // Set wins over a simultaneous write-one-to-clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~((req.wr && req.addr == timer_regs_pkg::OFF_STATUS)
                     ? req.wdata[timer_regs_pkg::ST_W-1:0] : '0)) | status_events;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq <= 1'b0;
      update_event <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
      update_event <= upd;
    end
  end

  // In input mode the channel reads the capture; in output mode the shadow
  function automatic logic [31:0] ch_read(input int i);
    ch_read = {16'h0000, mode[i].is_input ? ch_active_reg[i] : ch_shadow_reg[i]};
  endfunction : ch_read

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (req.rd) begin
      case (req.addr)
        timer_regs_pkg::OFF_RELOAD: reg_rdata <= reload_limit_value_reg;
        timer_regs_pkg::OFF_CH_ONE: reg_rdata <= ch_read(0);
        timer_regs_pkg::OFF_CH_TWO: reg_rdata <= ch_read(1);
        timer_regs_pkg::OFF_CH_THREE: reg_rdata <= ch_read(2);
        timer_regs_pkg::OFF_CTRL: reg_rdata <= {31'h0000_0000, run_reg};
        timer_regs_pkg::OFF_CH_MODE: reg_rdata <= mode_reg;
        timer_regs_pkg::OFF_COUNT: reg_rdata <= {16'h0000, counter_reg};
        timer_regs_pkg::OFF_STATUS: reg_rdata <= {25'h0000000, status_reg};
        timer_regs_pkg::OFF_MASK: reg_rdata <= {25'h0000000, mask_reg};
        default: reg_rdata <= timer_regs_pkg::READ_UNMAPPED;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end
endmodule : timer_reload_and_compare_regs
`default_nettype wire

// ---- test/timer_regs_sva.sv ----
/* Port checker for the timer register block.
   Bound from the bench top file; sees only the top-level ports. */
`timescale 1ns/1ps
`default_nettype none
module timer_regs_sva (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [2:0] capture_in,
  input wire logic [2:0] channel_output,
  input wire logic update_event,
  input wire logic irq
);
  logic [11:0] mode_reg;
  logic [6:0] mask_reg;
  logic lim_set_reg;
  logic [2:0] out_ok;
  assign out_ok = {mode_reg[10] & ~mode_reg[8], mode_reg[6] & ~mode_reg[4], mode_reg[2] & ~mode_reg[0]};
  // Software's view of mode and mask, since the design's copies are hidden
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode_reg <= 12'h000;
      mask_reg <= 7'h00;
      lim_set_reg <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h54) mode_reg <= reg_wdata[11:0];
      if (reg_addr == 8'h60) mask_reg <= reg_wdata[6:0];
      if (reg_addr == 8'h2c && reg_wdata != 32'h0) lim_set_reg <= 1'b1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr_rd;
    reg_wr && reg_addr == 8'h34 && !mode_reg[0] ##1 reg_rd && reg_addr == 8'h34;
  endsequence
  a_rd_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data not idle");
  a_rd_upper: assert property ($past(reg_rd) && $past(reg_addr[7:4]) == 4'h3 |-> reg_rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_hole_zero: assert property ($past(reg_rd) && $past(reg_addr) == 8'h40 |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  a_direct_write: assert property (s_wr_rd |=> reg_rdata[15:0] == $past(reg_wdata[15:0], 2))
    else $error("channel write lost");
  a_halt_zero: assert property (!lim_set_reg && !$past(reg_wr) && !$past(reg_wr, 2) && !$past(reg_wr, 3)
    |-> !update_event) else $error("update while limit zero");
  a_force_upd: assert property (reg_wr && reg_addr == 8'h50 && reg_wdata[1] |-> ##[1:3] update_event)
    else $error("forced update missing");
  // The registered output reflects the mode of the cycle before, so a mode
  // change is seen one edge late and is judged against the earlier mode
  a_out_gate: assert property ((channel_output & ~$past(out_ok)) == 3'b000)
    else $error("output on disabled channel");
  a_irq_mask: assert property (mask_reg == 7'h00 && $past(mask_reg) == 7'h00 && $past(mask_reg, 2) == 7'h00 |-> !irq)
    else $error("irq while masked");
endmodule : timer_regs_sva
`default_nettype wire

// ---- test/timer_reload_and_compare_regs_bench.sv ----
/* Bench for the timer register block: registers, compare, capture, irq.
   Needs the package, design and checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module timer_reload_and_compare_regs_bench;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [2:0] capture_in = 3'h0;
  logic rd_d = 1'b0;
  logic [31:0] reg_rdata;
  logic [2:0] channel_output;
  logic update_event;
  logic irq;
  logic [31:0] lfsr = 32'ha1a84cf4;
  logic [31:0] exp_q [$];
  int n_errors = 0;
  int cmp_count = 0;
  int k;
  int n;
  always #2 sys_clk = ~sys_clk;
  timer_reload_and_compare_regs DUT (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .capture_in, .channel_output, .update_event, .irq);
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    cmp_count++;
    if (seen !== want) begin
      n_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask : chk
  // One bus cycle; on a read d is the expected data, and wdata is ignored
  task automatic op(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= r;
    reg_addr <= a;
    reg_wdata <= d;
    if (r) exp_q.push_back(d);
    @(posedge sys_clk);
  endtask : op
  task automatic idle(input int c);
    repeat (c) op(1'b0, 1'b0, 8'h00, 32'h0);
  endtask : idle
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk(reg_rdata, exp_q.pop_front());
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    for (k = 0; k < 4; k++) op(1'b0, 1'b1, 8'h34 + 8'(4 * k), 32'h0);
    op(1'b0, 1'b1, 8'h2c, 32'h0);
    $display("test reset done");
    op(1'b1, 1'b0, 8'h54, 32'h444);
    for (k = 0; k < 3; k++) begin
      lfsr = nxt(lfsr);
      op(1'b1, 1'b0, 8'h34 + 8'(4 * k), lfsr | 32'h1);
      op(1'b0, 1'b1, 8'h34 + 8'(4 * k), {16'h0, lfsr[15:1], 1'b1});
    end
    idle(3);
    chk({29'h0, channel_output}, 32'h7);
    op(1'b1, 1'b0, 8'h34, 32'h0);
    idle(3);
    chk({29'h0, channel_output}, 32'h6);
    $display("test direct compare done");
    op(1'b1, 1'b0, 8'h54, 32'h666);
    op(1'b1, 1'b0, 8'h38, 32'h0);
    idle(3);
    chk({29'h0, channel_output}, 32'h6);
    op(1'b1, 1'b0, 8'h50, 32'h2);
    idle(3);
    chk({29'h0, channel_output}, 32'h4);
    $display("test shadow done");
    op(1'b1, 1'b0, 8'h50, 32'h1);
    idle(5);
    op(1'b0, 1'b1, 8'h58, 32'h0);
    op(1'b1, 1'b0, 8'h2c, 32'h4);
    idle(5);
    n = 0;
    // Any 50 consecutive cycles hold exactly ten reloads of a period-5 count
    repeat (50) begin
      idle(1);
      n += int'(update_event);
    end
    chk(32'(n), 32'ha);
    op(1'b1, 1'b0, 8'h50, 32'h0);
    $display("test reload done");
    op(1'b1, 1'b0, 8'h54, 32'h015);
    lfsr = nxt(lfsr);
    op(1'b1, 1'b0, 8'h58, {16'h0, lfsr[15:0]});
    capture_in <= 3'b011;
    idle(1);
    capture_in <= 3'b000;
    op(1'b0, 1'b1, 8'h34, {16'h0, lfsr[15:0]});
    op(1'b0, 1'b1, 8'h38, 32'h0);
    op(1'b1, 1'b0, 8'h34, 32'hbeef);
    op(1'b0, 1'b1, 8'h34, {16'h0, lfsr[15:0]});
    $display("test capture done");
    op(1'b1, 1'b0, 8'h60, 32'h10);
    idle(3);
    chk({31'h0, irq}, 32'h1);
    op(1'b1, 1'b0, 8'h5c, 32'h7f);
    idle(3);
    chk({31'h0, irq}, 32'h0);
    $display("test interrupt done");
    wrap_up();
  end
  // Several times the expected run length
  initial begin
    #8000;
    n_errors++;
    wrap_up();
  end
endmodule : timer_reload_and_compare_regs_bench
bind timer_reload_and_compare_regs timer_regs_sva chk_i (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .capture_in, .channel_output, .update_event, .irq);
`default_nettype wire
